// *** logic/lprs_cfg.svh ***
// Constants for the low-power and reset status block
`ifndef LPRS_CFG_SVH
`define LPRS_CFG_SVH
`define LPRS_ADDR_BRK_STAT  16'hFE00
`define LPRS_ADDR_RST_CAUSE 16'hFE01
`define LPRS_ADDR_BRK_CTRL  16'hFE03
`define LPRS_BRK_FLAG_BIT   1
`define LPRS_BREAK_CLEAR_ENABLE_BIT       7
`define LPRS_POR_BIT        7
`define LPRS_PIN_BIT        6
`define LPRS_WDOG_BIT       5
`define LPRS_ILLEGAL_OPCODE_FLAG_BIT       4
`define LPRS_ILLEGAL_ADDRESS_FLAG_BIT       3
`define LPRS_MON_BIT        2
`define LPRS_LVI_BIT        1
`define LPRS_REC_LONG       4096
`define LPRS_REC_SHORT      32
`define LPRS_CNT_W          13
`endif

// *** logic/lprs_pkg.sv ***
// Types for the low-power and reset status block
package lprs_pkg;
	typedef enum logic [1:0] {
		LPRS_RUN  = 2'b00,
		LPRS_WAIT = 2'b01,
		LPRS_STOP = 2'b10,
		LPRS_REC  = 2'b11
	} lprs_state_t;

	typedef struct packed {
		logic pin;
		logic wdog;
		logic illegal_opcode_flag;
		logic illegal_address_flag;
		logic mon;
		logic low_voltage_flag;
	} lprs_cause_t;

	typedef struct packed {
		logic       rd;
		logic       wr;
		logic [15:0] addr;
		logic [7:0]  wdata;
	} lprs_bus_t;
endpackage

// *** logic/lprs_top.sv ***
// Low-power mode sequencer and reset status registers
`timescale 1ns/1ps
`include "lprs_cfg.svh"

// Operation
// RL1: Wait or stop clears CPU interrupt mask
// RL2: Wait stops CPU clock, peripherals run
// RL3: Enabled interrupt wakes wait, stacking next cycle
// RL4: Wait also ends on reset or break
// RL5: Break in wait/stop sets break flag
// RL6: Watchdog runs in wait unless disabled
// RL7: Stop resets counter, gates both clocks
// RL8: Stop ends on interrupt, reset, break
// RL9: Recovery 4096 cycles, or 32 if short
// RL10: Crystal systems should keep short option clear
// RL11: Counter held in stop, then times recovery
// RL12: Three registers at FE00, FE01, FE03
// RL13: Break flag cleared by writing zero, reset
// RL14: Reset cause read clears all flags
// RL15: Power-on sets its flag, clears others
// RL16: Separate flags per reset cause
// RL17: Monitor entry reset sets its flag
// RL18: Bit 7 enables flag clearing in break
// RL19: Break-time clears persist; two-step stays protected
// RL20: Reset cause bit positions chosen here
module lprs_top #(
	parameter int REC_LONG  = `LPRS_REC_LONG,
	parameter int REC_SHORT = `LPRS_REC_SHORT
) (
	input  wire logic               sys_clk,
	input  wire logic               rst_b,
	input  wire logic               por_event,
	input  wire lprs_pkg::lprs_cause_t rst_cause,
	input  wire logic               rst_event,
	input  wire logic               wait_exec,
	input  wire logic               stop_exec,
	input  wire logic               irq_req,
	input  wire logic               break_req,
	input  wire logic               break_state,
	input  wire logic               watchdog_disable_option,
	input  wire logic               short_recovery_option,
	input  wire lprs_pkg::lprs_bus_t bus,
	output logic [7:0]              rdata,
	output logic                    clr_imask,
	output logic                    cpu_clk_en,
	output logic                    bus_clock_out_en,
	output logic                    oscillator_clock_en,
	output logic                    stack_start,
	output logic                    watchdog_run,
	output logic                    break_clear_ok
);

	// ==========================================================
	// Sequencer
	lprs_pkg::lprs_state_t state_reg;
	lprs_pkg::lprs_state_t state_next;
	logic [`LPRS_CNT_W-1:0] cnt_reg;
	logic [`LPRS_CNT_W-1:0] cnt_next;
	logic [`LPRS_CNT_W-1:0] rec_len;
	logic                   stack_next;
	logic                   wake_brk;

	assign rec_len = short_recovery_option ? `LPRS_CNT_W'(REC_SHORT)
	                                       : `LPRS_CNT_W'(REC_LONG); // RL9 RL10
	assign wake_brk = break_req &&
		(state_reg == lprs_pkg::LPRS_WAIT || state_reg == lprs_pkg::LPRS_STOP); // RL5

	always_comb begin
		state_next = state_reg;
		cnt_next   = cnt_reg;
		stack_next = 1'b0;
		case (state_reg)
			lprs_pkg::LPRS_RUN: begin
				if (stop_exec) begin
					state_next = lprs_pkg::LPRS_STOP;
					cnt_next   = '0; // RL7
				end else if (wait_exec) begin
					state_next = lprs_pkg::LPRS_WAIT;
				end
			end
			lprs_pkg::LPRS_WAIT: begin
				if (irq_req || break_req) begin // RL3 RL4
					state_next = lprs_pkg::LPRS_RUN;
					stack_next = 1'b1;
				end
			end
			lprs_pkg::LPRS_STOP: begin
				cnt_next = '0; // RL11
				if (irq_req || break_req) begin // RL8
					state_next = lprs_pkg::LPRS_REC;
				end
			end
			default: begin
				cnt_next = cnt_reg + `LPRS_CNT_W'(1); // RL11
				if (cnt_next == rec_len) begin // RL9
					state_next = lprs_pkg::LPRS_RUN;
					stack_next = 1'b1; // RL8
				end
			end
		endcase
	end

	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			state_reg   <= lprs_pkg::LPRS_RUN;
			cnt_reg     <= '0;
			stack_start <= 1'b0;
			clr_imask   <= 1'b0;
		end else if (rst_event) begin
			state_reg   <= lprs_pkg::LPRS_RUN; // RL4 RL8
			cnt_reg     <= '0;
			stack_start <= 1'b0;
			clr_imask   <= 1'b0;
		end else begin
			state_reg   <= state_next;
			cnt_reg     <= cnt_next;
			stack_start <= stack_next; // RL3
			clr_imask   <= wait_exec || stop_exec; // RL1
		end
	end

	// ==========================================================
	// Clock gating
	logic cpu_en_next;
	logic sys_en_next;
	assign cpu_en_next = (state_next == lprs_pkg::LPRS_RUN); // RL2
	assign sys_en_next = (state_next == lprs_pkg::LPRS_RUN) ||
	                     (state_next == lprs_pkg::LPRS_WAIT); // RL7

	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			cpu_clk_en          <= 1'b1;
			bus_clock_out_en    <= 1'b1;
			oscillator_clock_en <= 1'b1;
			watchdog_run        <= 1'b0;
		end else begin
			cpu_clk_en          <= cpu_en_next || rst_event;
			bus_clock_out_en    <= sys_en_next || rst_event;
			oscillator_clock_en <= sys_en_next || state_next == lprs_pkg::LPRS_REC
			                       || rst_event;
			watchdog_run        <= !watchdog_disable_option &&
			                       state_next != lprs_pkg::LPRS_STOP; // RL6
		end
	end

	// ==========================================================
	// Registers
	logic brk_flag_reg;
	logic break_clear_enable_reg;
	logic por_flag_reg;
	lprs_pkg::lprs_cause_t cause_reg;
	logic sel_stat;
	logic sel_cause;
	logic sel_ctrl;
	logic clr_allowed;
	logic [7:0] rd_mux;

	assign sel_stat  = (bus.addr == `LPRS_ADDR_BRK_STAT); // RL12
	assign sel_cause = (bus.addr == `LPRS_ADDR_RST_CAUSE);
	assign sel_ctrl  = (bus.addr == `LPRS_ADDR_BRK_CTRL);
	assign clr_allowed = !break_state || break_clear_enable_reg; // RL18 RL19

	always_comb begin
		rd_mux = 8'h00;
		if (sel_stat) begin
			rd_mux[`LPRS_BRK_FLAG_BIT] = brk_flag_reg;
		end else if (sel_cause) begin
			rd_mux[`LPRS_POR_BIT]  = por_flag_reg; // RL20
			rd_mux[`LPRS_PIN_BIT]  = cause_reg.pin;
			rd_mux[`LPRS_WDOG_BIT] = cause_reg.wdog;
			rd_mux[`LPRS_ILLEGAL_OPCODE_FLAG_BIT] = cause_reg.illegal_opcode_flag;
			rd_mux[`LPRS_ILLEGAL_ADDRESS_FLAG_BIT] = cause_reg.illegal_address_flag;
			rd_mux[`LPRS_MON_BIT]  = cause_reg.mon;
			rd_mux[`LPRS_LVI_BIT]  = cause_reg.low_voltage_flag;
		end else if (sel_ctrl) begin
			rd_mux[`LPRS_BREAK_CLEAR_ENABLE_BIT] = break_clear_enable_reg;
		end
	end

	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			brk_flag_reg <= 1'b0;
			break_clear_enable_reg     <= 1'b0;
			rdata        <= 8'h00;
			break_clear_ok <= 1'b0;
		end else if (rst_event) begin
			brk_flag_reg <= 1'b0; // RL13
			break_clear_enable_reg     <= 1'b0;
			rdata        <= 8'h00;
			break_clear_ok <= !break_state; // RL18
		end else begin
			rdata <= bus.rd ? rd_mux : 8'h00;
			break_clear_ok <= clr_allowed; // RL18
			if (wake_brk) begin
				brk_flag_reg <= 1'b1; // RL5
			end else if (bus.wr && sel_stat && clr_allowed &&
			             !bus.wdata[`LPRS_BRK_FLAG_BIT]) begin
				brk_flag_reg <= 1'b0; // RL13
			end
			if (bus.wr && sel_ctrl) begin
				break_clear_enable_reg <= bus.wdata[`LPRS_BREAK_CLEAR_ENABLE_BIT]; // RL18
			end
		end
	end

	// Reset cause: latched on reset event, kept through it
	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			por_flag_reg <= 1'b1;
			cause_reg    <= '0;
		end else if (por_event) begin
			por_flag_reg <= 1'b1; // RL15
			cause_reg    <= '0;
		end else if (rst_event) begin
			por_flag_reg <= 1'b0;
			cause_reg    <= rst_cause; // RL16 RL17
		end else if (bus.rd && sel_cause && clr_allowed) begin
			por_flag_reg <= 1'b0; // RL14
			cause_reg    <= '0;
		end
	end

endmodule

// *** tb/lprs_sva.sv ***
// Port assertions for the low-power block
`timescale 1ns/1ps
module lprs_sva #(
	parameter int REC_LONG  = 4096,
	parameter int REC_SHORT = 32
) (
	input wire logic sys_clk,
	input wire logic rst_b,
	input wire logic rst_event,
	input wire logic wait_exec,
	input wire logic stop_exec,
	input wire logic irq_req,
	input wire logic break_state,
	input wire logic watchdog_disable_option,
	input wire logic short_recovery_option,
	input wire lprs_pkg::lprs_bus_t bus,
	input wire logic [7:0] rdata,
	input wire logic clr_imask,
	input wire logic cpu_clk_en,
	input wire logic bus_clock_out_en,
	input wire logic oscillator_clock_en,
	input wire logic stack_start,
	input wire logic watchdog_run,
	input wire logic break_clear_ok
);
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!rst_b);
	logic [15:0] rec_cnt;
	// Cycles spent in recovery
	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) rec_cnt <= 16'h0000;
		else rec_cnt <= (oscillator_clock_en && !bus_clock_out_en) ? rec_cnt + 16'h0001 : 16'h0000;
	end
	imask_clear_a: assert property ((wait_exec || stop_exec) && cpu_clk_en |=> clr_imask)
		else $error("mask not cleared");
	wait_clocks_a: assert property (wait_exec && !stop_exec && cpu_clk_en && !rst_event
		|=> !cpu_clk_en && bus_clock_out_en) else $error("wait clocks wrong");
	wait_wake_a: assert property (!cpu_clk_en && bus_clock_out_en && irq_req && !rst_event
		|=> stack_start) else $error("no wake from wait");
	stop_gate_a: assert property (stop_exec && cpu_clk_en && !rst_event
		|=> !bus_clock_out_en && !oscillator_clock_en) else $error("stop clocks on");
	wdog_wait_a: assert property (!watchdog_disable_option && !cpu_clk_en && bus_clock_out_en
		|-> watchdog_run) else $error("watchdog idle in wait");
	unmapped_a: assert property (bus.rd && bus.addr == 16'hFE02 |=> rdata == 8'h00)
		else $error("unmapped read nonzero");
	cause_clear_a: assert property (bus.rd && bus.addr == 16'hFE01 && !break_state && !rst_event
		##1 !rst_event ##1 bus.rd && bus.addr == 16'hFE01 |=> rdata == 8'h00)
		else $error("cause not cleared");
	break_ok_a: assert property (!break_state |=> break_clear_ok)
		else $error("clear blocked outside break");
	rec_len_a: assert property (rec_cnt <= (short_recovery_option ? REC_SHORT : REC_LONG) + 1)
		else $error("recovery too long");
endmodule

// *** tb/lprs_cpu.sv ***
// CPU-side interrupt source model
`timescale 1ns/1ps
module lprs_cpu (
	input  wire logic sys_clk,
	input  wire logic rst_b,
	input  wire logic raise,
	input  wire logic stack_start,
	output logic      irq_req
);
	// Request held until stacking begins
	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) irq_req <= 1'b0;
		else if (raise) irq_req <= 1'b1;
		else if (stack_start) irq_req <= 1'b0;
	end
endmodule

// *** tb/tb_lprs_top.sv ***
// Self-checking bench for the low-power block
`timescale 1ns/1ps
module tb_lprs_top;
	logic sys_clk = 1'b0, rst_b = 1'b0, rst_event = 1'b0, wait_exec = 1'b0, stop_exec = 1'b0;
	logic raise = 1'b0, break_req = 1'b0, break_state = 1'b0, short_opt = 1'b0, irq_req;
	logic por_ev = 1'b0, wdog_dis = 1'b0;
	logic clr_imask, cpu_en, bus_en, osc_en, stack_start, wdog_run, clr_ok;
	logic [7:0] rdata;
	lprs_pkg::lprs_cause_t rst_cause = '0;
	lprs_pkg::lprs_bus_t bus = '0;
	int fail_count = 0, n_tests = 0, cyc = 0;
	always #5 sys_clk = ~sys_clk;
	lprs_top #(.REC_LONG(40), .REC_SHORT(8)) u_lprs_top (.sys_clk(sys_clk), .rst_b(rst_b),
		.por_event(por_ev), .rst_cause(rst_cause), .rst_event(rst_event), .wait_exec(wait_exec),
		.stop_exec(stop_exec), .irq_req(irq_req), .break_req(break_req),
		.break_state(break_state), .watchdog_disable_option(wdog_dis),
		.short_recovery_option(short_opt), .bus(bus), .rdata(rdata), .clr_imask(clr_imask),
		.cpu_clk_en(cpu_en), .bus_clock_out_en(bus_en), .oscillator_clock_en(osc_en),
		.stack_start(stack_start), .watchdog_run(wdog_run), .break_clear_ok(clr_ok));
	lprs_cpu u_lprs_cpu (.sys_clk(sys_clk), .rst_b(rst_b), .raise(raise),
		.stack_start(stack_start), .irq_req(irq_req));
	task automatic tick(input int n);
		repeat (n) @(negedge sys_clk);
	endtask
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		n_tests++;
		if (got !== exp) begin
			fail_count++;
			$display("ERROR %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic acc(input logic w, input logic [15:0] a, input logic [7:0] d);
		bus = '{rd: !w, wr: w, addr: a, wdata: d};
		tick(1);
		if (!w) chk(rdata, d);
		bus = '0;
		tick(1);
	endtask
	task automatic tally_and_finish;
		$display("checks %0d mismatches %0d", n_tests, fail_count);
		if (fail_count == 0 && n_tests > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask
	task automatic enter(input logic stop, input logic brk);
		wait_exec = !stop;
		stop_exec = stop;
		tick(1);
		wait_exec = 1'b0;
		stop_exec = 1'b0;
		chk(8'({clr_imask, cpu_en, bus_en, osc_en, wdog_run}), stop ? 8'h10 : 8'h17);
		raise = !brk;
		break_req = brk;
		tick(1);
		raise = 1'b0;
		break_req = 1'b0;
	endtask
	task automatic stop_rec(input logic brk, input int rec);
		int n;
		n = 0;
		enter(1'b1, brk);
		while (!stack_start && n < 5000) begin
			n += int'(osc_en && !bus_en);
			tick(1);
		end
		chk(8'(n >= rec && n <= rec + 1), 8'h01);
		chk(8'({cpu_en, bus_en, osc_en}), 8'h07);
	endtask
	always @(posedge sys_clk) begin
		cyc++;
		if (cyc == 20000) begin
			fail_count++;
			tally_and_finish();
		end
	end
	initial begin
		tick(16);
		rst_b = 1'b1;
		tick(1);
		acc(1'b0, 16'hFE01, 8'h80);
		acc(1'b0, 16'hFE01, 8'h00);
		acc(1'b0, 16'hFE03, 8'h00);
		acc(1'b0, 16'hFE02, 8'h00);
		for (int i = 0; i < 6; i++) begin
			rst_cause = 6'(1 << i);
			rst_event = 1'b1;
			tick(1);
			rst_event = 1'b0;
			acc(1'b0, 16'hFE01, 8'(2 << i));
		end
		enter(1'b0, 1'b0);
		tick(1);
		chk(8'({stack_start, cpu_en}), 8'h03);
		rst_cause = 6'h20;
		rst_event = 1'b1;
		tick(1);
		rst_event = 1'b0;
		enter(1'b0, 1'b1);
		tick(2);
		chk(8'(cpu_en), 8'h01);
		break_state = 1'b1;
		acc(1'b1, 16'hFE00, 8'h00);
		acc(1'b0, 16'hFE00, 8'h02);
		acc(1'b0, 16'hFE01, 8'h40);
		acc(1'b0, 16'hFE01, 8'h40);
		chk(8'(clr_ok), 8'h00);
		acc(1'b1, 16'hFE03, 8'h80);
		acc(1'b0, 16'hFE03, 8'h80);
		acc(1'b1, 16'hFE00, 8'h00);
		acc(1'b0, 16'hFE01, 8'h40);
		acc(1'b0, 16'hFE01, 8'h00);
		break_state = 1'b0;
		acc(1'b0, 16'hFE00, 8'h00);
		short_opt = 1'b1;
		stop_rec(1'b0, 8);
		short_opt = 1'b0;
		stop_rec(1'b1, 40);
		acc(1'b0, 16'hFE00, 8'h02);
		por_ev = 1'b1;
		tick(1);
		por_ev = 1'b0;
		acc(1'b0, 16'hFE01, 8'h80);
		wdog_dis = 1'b1;
		tick(2);
		chk(8'(wdog_run), 8'h00);
		wdog_dis = 1'b0;
		tick(2);
		chk(8'(wdog_run), 8'h01);
		tally_and_finish();
	end
endmodule
bind lprs_top lprs_sva #(.REC_LONG(REC_LONG), .REC_SHORT(REC_SHORT)) u_lprs_sva (.*);
